// ==== inc/dwp_pkg.sv ====
// Shared constants for the width-packing DMA engine: register map,
// field positions, reset values and bus encodings.
// Assumes a 32-bit register bus and a 32-bit system bus.
package dwp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CFG_W  = 12;
  localparam int CNT_W  = 16;
  localparam int FLG_W  = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h00;
  localparam logic [7:0] OFS_FLAG_CLEAR  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
  localparam logic [7:0] OFS_ENGINE_STAT = 8'h0c;
  localparam logic [3:0] REG_CFG         = 4'h0;
  localparam logic [3:0] REG_CNT         = 4'h4;
  localparam logic [3:0] REG_PADDR       = 4'h8;
  localparam logic [3:0] REG_MADDR       = 4'hc;
  localparam int         CH_SEL_BIT      = 7;

  // ----------------------------------------------------------------
  // Channel config fields
  // ----------------------------------------------------------------
  localparam int CFG_EN       = 0;
  localparam int CFG_DONE_IE  = 1;
  localparam int CFG_HALF_IE  = 2;
  localparam int CFG_ERR_IE   = 3;
  localparam int CFG_DIR      = 4;
  localparam int CFG_PERIPH_ADDR_STEP_ON     = 6;
  localparam int CFG_MEM_ADDR_STEP_ON     = 7;
  localparam int CFG_PERIPH_ITEM_SIZE_LO = 8;
  localparam int CFG_MEM_ITEM_SIZE_LO = 10;

  // ----------------------------------------------------------------
  // Status group per channel
  // ----------------------------------------------------------------
  localparam int FLG_SUM  = 0;
  localparam int FLG_DONE = 1;
  localparam int FLG_HALF = 2;
  localparam int FLG_ERR  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST  = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [31:0]      WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Item size and system bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE        = 2'h0;
  localparam logic [1:0] SZ_HALF        = 2'h1;
  localparam logic [1:0] SZ_WORD        = 2'h2;
  localparam logic [1:0] HTRANS_IDLE    = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [3:0] SEL_FULL       = 4'hf;

endpackage

// ==== logic/dwp_addr_step.sv ====
// Address stepper: next pointer of one side after an item.
// Assumes the item size uses the system bus size encoding.
`timescale 1ns/1ps
module dwp_addr_step (
  input  wire logic [31:0] addr_i,    // Current pointer
  input  wire logic [1:0]  size_i,    // Item size of this side
  input  wire logic        on_i,      // Stepping enabled for this side
  output logic      [31:0] next_o     // Pointer for the next item
);

  // ----------------------------------------------------------------
  // Step by 1, 2 or 4; the reserved code steps as a word
  // ----------------------------------------------------------------
  logic [31:0] step;
  always_comb begin
    case (size_i)
      dwp_pkg::SZ_BYTE: step = 32'h0000_0001;
      dwp_pkg::SZ_HALF: step = 32'h0000_0002;
      default:          step = 32'h0000_0004;
    endcase
    next_o = on_i ? addr_i + step : addr_i;
  end

endmodule

// ==== logic/dwp_width_pack.sv ====
// Width converter: takes the read word and the item sizes and forms
// the write word with byte and halfword write items replicated across all byte lanes.
// Assumes little-endian lane order on the system bus.
`timescale 1ns/1ps
module dwp_width_pack (
  input  wire logic [31:0] rdata_i,    // Word returned by the read
  input  wire logic [1:0]  src_lane_i, // Low bits of the read address
  input  wire logic [1:0]  src_size_i, // Read item size
  input  wire logic [1:0]  dst_size_i, // Write item size
  output logic      [31:0] wdata_o     // Word to drive on the write
);

  // ----------------------------------------------------------------
  // Extract the item, zero-extend, then truncate and replicate
  // ----------------------------------------------------------------
  logic [31:0] shifted;
  logic [31:0] item;
  always_comb begin
    shifted = rdata_i >> {src_lane_i, 3'h0};
    case (src_size_i)
      dwp_pkg::SZ_BYTE: item = {24'h00_0000, shifted[7:0]};
      dwp_pkg::SZ_HALF: item = {16'h0000, rdata_i[{src_lane_i[1], 4'h0} +: 16]};
      default:          item = rdata_i;
    endcase
    // Narrow writes fill every lane so a size-blind slave still
    // stores the right value at the aligned word
    case (dst_size_i)
      dwp_pkg::SZ_BYTE: wdata_o = {4{item[7:0]}};
      dwp_pkg::SZ_HALF: wdata_o = {2{item[15:0]}};
      default:          wdata_o = item;
    endcase
  end

endmodule

// ==== logic/dwp_dma_core.sv ====
// Eight-channel DMA engine with per-item width conversion, narrow
// write lane replication and transfer-error handling.
// Assumes a classic Wishbone register master and a single-master
// system bus with one clock, shared with this block.
//
// Operation
// - Equal widths: copy item, step both by size
// - Byte to half: zero-extend, steps one and two
// - Byte to word: zero-extend, destination steps four
// - Half to byte: low byte written, steps two/one
// - Half to word: upper sixteen bits zero
// - Word to byte: bits seven to zero written
// - Word to half: low halfword, steps four/two
// - Each item: one read then one write
// - Register port refuses anything but full words
// - Narrow writes: true size, data on all lanes
// - Bus error response is a channel transfer error
// - Transfer error clears the channel enable bit
// - Error flag set; interrupt only if enabled
// - Flags set by hardware, cleared writing one
// - Four flags: summary, done, half, error
// - Incrementing side steps by its item size
`timescale 1ns/1ps
module dwp_dma_core #(
  parameter int NUM_CH = dwp_pkg::NUM_CH      // Channel count
) (
  input  wire logic              clk_i,       // System clock
  input  wire logic              rst_i,       // Synchronous reset
  input  wire logic              wb_cyc_i,    // Register bus cycle
  input  wire logic              wb_stb_i,    // Register bus strobe
  input  wire logic              wb_we_i,     // Register write
  input  wire logic [7:0]        wb_adr_i,    // Register byte address
  input  wire logic [3:0]        wb_sel_i,    // Byte selects
  input  wire logic [31:0]       wb_dat_i,    // Register write data
  output logic      [31:0]       wb_dat_o,    // Register read data
  output logic                   wb_ack_o,    // Access done
  output logic                   wb_err_o,    // Access refused
  output logic                   irq_o,       // Unmasked status pending
  output logic      [NUM_CH-1:0] chan_irq_o,  // Per-channel request
  output logic      [31:0]       haddr_o,     // System bus address
  output logic      [1:0]        htrans_o,    // Transfer type
  output logic                   hwrite_o,    // Write not read
  output logic      [2:0]        hsize_o,     // Transfer size
  output logic      [31:0]       hwdata_o,    // Write data
  input  wire logic [31:0]       hrdata_i,    // Read data
  input  wire logic              hready_i,    // Transfer ready
  input  wire logic              hresp_i      // Error response
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DWP_IDLE, DWP_RD_ADR, DWP_RD_DAT, DWP_WR_ADR, DWP_WR_DAT
  } dwp_state_t;

  localparam int CW = dwp_pkg::CFG_W;
  localparam int NW = dwp_pkg::CNT_W;
  localparam logic [NW-1:0] CNT_ZERO      = '0;
  localparam logic [NW-1:0] CNT_ONE       = 16'h0001;
  localparam logic [1:0]    HTRANS_IDLE_C = dwp_pkg::HTRANS_IDLE;

  dwp_state_t        st_q;
  logic [2:0]        ch_q;
  logic [CW-1:0]     cfg_q      [NUM_CH];
  logic [NW-1:0]     cnt_q      [NUM_CH];
  logic [NW-1:0]     init_q     [NUM_CH];
  logic [31:0]       paddr_q    [NUM_CH];
  logic [31:0]       maddr_q    [NUM_CH];
  logic [31:0]       cur_pa_q   [NUM_CH];
  logic [31:0]       cur_ma_q   [NUM_CH];
  logic [31:0]       status_q;
  logic [31:0]       mask_q;
  logic [31:0]       status_set;
  logic [31:0]       rd_data;
  logic              ack_q;
  logic              err_q;
  logic [31:0]       rdat_q;
  logic [31:0]       haddr_q;
  logic [1:0]        htrans_q;
  logic              hwrite_q;
  logic [1:0]        hsize_q;
  logic [31:0]       hwdata_q;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic       req;
  logic       bad_sel;
  logic       wr_ok;
  logic       ch_hit;
  logic [2:0] reg_ch;
  logic [3:0] reg_ofs;
  assign req     = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign bad_sel = wb_sel_i != dwp_pkg::SEL_FULL;
  assign wr_ok   = req & wb_we_i & ~bad_sel;
  assign ch_hit  = wb_adr_i[dwp_pkg::CH_SEL_BIT];
  assign reg_ch  = wb_adr_i[6:4];
  assign reg_ofs = wb_adr_i[3:0];

  // ----------------------------------------------------------------
  // Channel pick: lowest ready channel; a cleared enable or an empty
  // count keeps a channel off the bus
  // ----------------------------------------------------------------
  logic       pick_ok;
  logic [2:0] pick_ch;
  always_comb begin
    pick_ok = 1'b0;
    pick_ch = 3'h0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (cfg_q[c][dwp_pkg::CFG_EN] && cnt_q[c] != CNT_ZERO) begin
        pick_ok = 1'b1;
        pick_ch = c[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source and destination view of the active or picked channel
  // ----------------------------------------------------------------
  logic [2:0]  vch;
  logic        dir;
  logic [1:0]  periph_item_size;
  logic [1:0]  mem_item_size;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [1:0]  src_size;
  logic [1:0]  dst_size;
  logic        src_on;
  logic        dst_on;
  always_comb begin
    vch   = (st_q == DWP_IDLE) ? pick_ch : ch_q;
    dir   = cfg_q[vch][dwp_pkg::CFG_DIR];
    periph_item_size = cfg_q[vch][dwp_pkg::CFG_PERIPH_ITEM_SIZE_LO +: 2];
    mem_item_size = cfg_q[vch][dwp_pkg::CFG_MEM_ITEM_SIZE_LO +: 2];
    // Direction low reads the peripheral side, high reads memory
    src_addr = dir ? cur_ma_q[vch] : cur_pa_q[vch];
    dst_addr = dir ? cur_pa_q[vch] : cur_ma_q[vch];
    src_size = dir ? mem_item_size : periph_item_size;
    dst_size = dir ? periph_item_size : mem_item_size;
    src_on   = dir ? cfg_q[vch][dwp_pkg::CFG_MEM_ADDR_STEP_ON] : cfg_q[vch][dwp_pkg::CFG_PERIPH_ADDR_STEP_ON];
    dst_on   = dir ? cfg_q[vch][dwp_pkg::CFG_PERIPH_ADDR_STEP_ON] : cfg_q[vch][dwp_pkg::CFG_MEM_ADDR_STEP_ON];
  end

  logic [31:0] src_next;
  logic [31:0] dst_next;
  logic [31:0] pack_data;

  dwp_addr_step u_src_step (
    .addr_i (src_addr),
    .size_i (src_size),
    .on_i   (src_on),
    .next_o (src_next)
  );

  dwp_addr_step u_dst_step (
    .addr_i (dst_addr),
    .size_i (dst_size),
    .on_i   (dst_on),
    .next_o (dst_next)
  );

  dwp_width_pack u_pack (
    .rdata_i    (hrdata_i),
    .src_lane_i (src_addr[1:0]),
    .src_size_i (src_size),
    .dst_size_i (dst_size),
    .wdata_o    (pack_data)
  );

  // ----------------------------------------------------------------
  // Item events
  // ----------------------------------------------------------------
  logic item_done;
  logic xfer_err;
  logic last_item;
  logic half_item;
  assign item_done = (st_q == DWP_WR_DAT) & hready_i & ~hresp_i;
  assign xfer_err  = ((st_q == DWP_RD_DAT) | (st_q == DWP_WR_DAT)) & hresp_i;
  assign last_item = cnt_q[ch_q] == CNT_ONE;
  assign half_item = (cnt_q[ch_q] - CNT_ONE) == (init_q[ch_q] >> 1);

  // ----------------------------------------------------------------
  // Transfer engine: read one item, then write it (one per count)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= DWP_IDLE;
      ch_q     <= 3'h0;
      haddr_q  <= dwp_pkg::WORD_RST;
      htrans_q <= HTRANS_IDLE_C;
      hwrite_q <= 1'b0;
      hsize_q  <= dwp_pkg::SZ_BYTE;
      hwdata_q <= dwp_pkg::WORD_RST;
    end else begin
      case (st_q)
        DWP_IDLE: begin
          if (pick_ok) begin
            ch_q     <= pick_ch;
            haddr_q  <= src_addr;
            hsize_q  <= src_size;
            hwrite_q <= 1'b0;
            htrans_q <= dwp_pkg::HTRANS_NONSEQ;
            st_q     <= DWP_RD_ADR;
          end
        end
        DWP_RD_ADR: begin
          if (hready_i) begin
            htrans_q <= HTRANS_IDLE_C;
            st_q     <= DWP_RD_DAT;
          end
        end
        DWP_RD_DAT: begin
          if (hresp_i) begin
            st_q <= DWP_IDLE;
          end else if (hready_i) begin
            hwdata_q <= pack_data;
            haddr_q  <= dst_addr;
            hsize_q  <= dst_size;
            hwrite_q <= 1'b1;
            htrans_q <= dwp_pkg::HTRANS_NONSEQ;
            st_q     <= DWP_WR_ADR;
          end
        end
        DWP_WR_ADR: begin
          if (hready_i) begin
            htrans_q <= HTRANS_IDLE_C;
            st_q     <= DWP_WR_DAT;
          end
        end
        DWP_WR_DAT: begin
          if (hresp_i || hready_i) begin
            hwrite_q <= 1'b0;
            st_q     <= DWP_IDLE;
          end
        end
        default: st_q <= DWP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel registers and live pointers. A hardware disable on error
  // wins over a software enable in the same cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c]    <= dwp_pkg::CFG_RST;
        cnt_q[c]    <= dwp_pkg::CNT_RST;
        init_q[c]   <= dwp_pkg::CNT_RST;
        paddr_q[c]  <= dwp_pkg::WORD_RST;
        maddr_q[c]  <= dwp_pkg::WORD_RST;
        cur_pa_q[c] <= dwp_pkg::WORD_RST;
        cur_ma_q[c] <= dwp_pkg::WORD_RST;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_ok && ch_hit && reg_ch == c[2:0]) begin
          case (reg_ofs)
            dwp_pkg::REG_CFG: begin
              cfg_q[c] <= wb_dat_i[CW-1:0];
              // Enabling restarts the live pointers from the bases
              if (wb_dat_i[dwp_pkg::CFG_EN] && !cfg_q[c][dwp_pkg::CFG_EN]) begin
                cur_pa_q[c] <= paddr_q[c];
                cur_ma_q[c] <= maddr_q[c];
              end
            end
            dwp_pkg::REG_CNT: begin
              // Count is only reloadable while the channel is off
              if (!cfg_q[c][dwp_pkg::CFG_EN]) begin
                cnt_q[c]  <= wb_dat_i[NW-1:0];
                init_q[c] <= wb_dat_i[NW-1:0];
              end
            end
            dwp_pkg::REG_PADDR: paddr_q[c] <= wb_dat_i;
            dwp_pkg::REG_MADDR: maddr_q[c] <= wb_dat_i;
            default: ;
          endcase
        end
        if (item_done && ch_q == c[2:0]) begin
          cur_pa_q[c] <= dir ? dst_next : src_next;
          cur_ma_q[c] <= dir ? src_next : dst_next;
          cnt_q[c]    <= cnt_q[c] - CNT_ONE;
        end
        if (xfer_err && ch_q == c[2:0]) begin
          cfg_q[c][dwp_pkg::CFG_EN] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: hardware sets, writing one clears, set wins
  // ----------------------------------------------------------------
  always_comb begin
    status_set = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ch_q == c[2:0]) begin
        status_set[c*4 + dwp_pkg::FLG_DONE] = item_done & last_item;
        status_set[c*4 + dwp_pkg::FLG_HALF] = item_done & half_item;
        status_set[c*4 + dwp_pkg::FLG_ERR]  = xfer_err;
        status_set[c*4 + dwp_pkg::FLG_SUM]  = xfer_err | item_done &
                                              (last_item | half_item);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= dwp_pkg::WORD_RST;
    end else if (wr_ok && !ch_hit && wb_adr_i == dwp_pkg::OFS_FLAG_CLEAR) begin
      status_q <= (status_q & ~wb_dat_i) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  // Mask register gates the summed interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= dwp_pkg::WORD_RST;
    end else if (wr_ok && !ch_hit && wb_adr_i == dwp_pkg::OFS_IRQ_MASK) begin
      mask_q <= wb_dat_i;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  assign irq_o = |(status_q & mask_q);
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      chan_irq_o[c] =
        status_q[c*4 + dwp_pkg::FLG_ERR]  & cfg_q[c][dwp_pkg::CFG_ERR_IE] |
        status_q[c*4 + dwp_pkg::FLG_DONE] & cfg_q[c][dwp_pkg::CFG_DONE_IE] |
        status_q[c*4 + dwp_pkg::FLG_HALF] & cfg_q[c][dwp_pkg::CFG_HALF_IE];
    end
  end

  // ----------------------------------------------------------------
  // Register read mux; unmapped and write-only offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    if (ch_hit) begin
      case (reg_ofs)
        dwp_pkg::REG_CFG:   rd_data = {20'h0_0000, cfg_q[reg_ch]};
        dwp_pkg::REG_CNT:   rd_data = {16'h0000, cnt_q[reg_ch]};
        dwp_pkg::REG_PADDR: rd_data = paddr_q[reg_ch];
        dwp_pkg::REG_MADDR: rd_data = maddr_q[reg_ch];
        default:            rd_data = '0;
      endcase
    end else begin
      case (wb_adr_i)
        dwp_pkg::OFS_IRQ_STATUS:  rd_data = status_q;
        dwp_pkg::OFS_IRQ_MASK:    rd_data = mask_q;
        dwp_pkg::OFS_ENGINE_STAT: rd_data = {28'h000_0000, ch_q, st_q != DWP_IDLE};
        default:                  rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus answer one cycle after the request; narrow access faults
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= dwp_pkg::WORD_RST;
    end else begin
      ack_q <= req & ~bad_sel;
      err_q <= req & bad_sel;
      if (req && !wb_we_i && !bad_sel) begin
        rdat_q <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // System bus outputs. Narrow sizes go out as they are so that a
  // size-aware slave writes just its lanes
  // ----------------------------------------------------------------
  assign haddr_o  = haddr_q;
  assign htrans_o = htrans_q;
  assign hwrite_o = hwrite_q;
  assign hsize_o  = {1'b0, hsize_q};
  assign hwdata_o = hwdata_q;

endmodule

// ==== testbench/dwp_monitor.sv ====
// Port checker for the width-packing DMA engine.
// Assumes it is bound to dwp_dma_core, one clock, sync reset.
`timescale 1ns/1ps
module dwp_monitor (
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Sync reset
  input  wire logic        wb_cyc_i,  // Register cycle
  input  wire logic        wb_stb_i,  // Register strobe
  input  wire logic [3:0]  wb_sel_i,  // Byte selects
  input  wire logic        wb_ack_o,  // Access done
  input  wire logic        wb_err_o,  // Access refused
  input  wire logic [1:0]  htrans_o,  // Transfer type
  input  wire logic        hwrite_o,  // Write not read
  input  wire logic [2:0]  hsize_o,   // Transfer size
  input  wire logic [31:0] hwdata_o,  // Write data
  input  wire logic        hready_i,  // Slave ready
  input  wire logic        hresp_i    // Error response
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------
  // Bus phases
  // ------------------------------
  sequence rd_acc; htrans_o == dwp_pkg::HTRANS_NONSEQ && !hwrite_o && hready_i; endsequence
  sequence wr_acc; htrans_o == dwp_pkg::HTRANS_NONSEQ && hwrite_o && hready_i; endsequence
  sequence wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  // Narrow writes must look right to a slave that ignores the size
  byte_lanes_a: assert property (wr_acc ##0 hsize_o == 3'h0 |->
    hwdata_o == {4{hwdata_o[7:0]}}) else $error("byte not on all lanes");
  half_lanes_a: assert property (wr_acc ##0 hsize_o == 3'h1 |->
    hwdata_o == {2{hwdata_o[15:0]}}) else $error("half not on both halves");
  word_ack_a: assert property (wb_req ##0 wb_sel_i == dwp_pkg::SEL_FULL |=>
    wb_ack_o && !wb_err_o) else $error("full word access not acked");
  narrow_err_a: assert property (wb_req ##0 wb_sel_i != dwp_pkg::SEL_FULL |=>
    wb_err_o && !wb_ack_o) else $error("narrow access not refused");
  read_then_write_a: assert property (rd_acc ##1 (hready_i && !hresp_i) |=>
    wr_acc) else $error("read not followed by write");
  no_write_after_a: assert property (rd_acc ##1 hresp_i |=>
    (!(htrans_o != dwp_pkg::HTRANS_IDLE && hwrite_o))[*8]) else $error("write after failed read");
  wdata_hold_a: assert property (wr_acc ##1 !hready_i |=> $stable(hwdata_o))
    else $error("write data moved while stalled");
  error_idle_a: assert property (hresp_i |=> (htrans_o == dwp_pkg::HTRANS_IDLE)[*8])
    else $error("transfers after error");
endmodule
bind dwp_dma_core dwp_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .htrans_o(htrans_o), .hwrite_o(hwrite_o), .hsize_o(hsize_o), .hwdata_o(hwdata_o),
  .hready_i(hready_i), .hresp_i(hresp_i));

// ==== testbench/dwp_ahb_mem.sv ====
// Behavioural system bus memory, 256 bytes, with a reserved region.
// Assumes one single-master bus on the engine's clock.
`timescale 1ns/1ps
module dwp_ahb_mem (
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Sync reset
  input  wire logic        slow_i,    // One wait state per data phase, none on an error response
  input  wire logic [31:0] haddr_i,   // Address
  input  wire logic [1:0]  htrans_i,  // Transfer type
  input  wire logic        hwrite_i,  // Write not read
  input  wire logic [2:0]  hsize_i,   // Size
  input  wire logic [31:0] hwdata_i,  // Write data
  output logic      [31:0] hrdata_o,  // Read data
  output logic             hready_o,  // Ready
  output logic             hresp_o    // Error
);
  logic [7:0]  mem [0:255];
  logic [31:0] ph_a;
  logic [2:0]  ph_s;
  logic        ph_w;
  logic        dph;
  logic        wait_q;
  logic [7:0]  base;
  logic [31:0] word;
  // ------------------------------
  // Data phase
  // ------------------------------
  assign base     = {ph_a[7:2], 2'h0};
  assign word     = {mem[base+8'h3], mem[base+8'h2], mem[base+8'h1], mem[base]};
  assign hresp_o  = dph && ph_a[31]; // Upper half is reserved space
  assign hready_o = !dph || hresp_o || !slow_i || wait_q;
  assign hrdata_o = (dph && !ph_w) ? word : ~word; // Released bus never repeats data
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hb0 + i[7:0];
  // Lanes stored by true size; a size-blind slave keeps the whole word
  always @(posedge clk_i) begin
    wait_q <= dph && !hready_o;
    if (dph && hready_o && ph_w && !hresp_o) begin
      for (int j = 0; j < 4; j++)
        if ((j >> ph_s) == (ph_a[1:0] >> ph_s)) mem[base+j[7:0]] <= hwdata_i[8*j+:8];
    end
    if (rst_i) begin
      dph <= 1'b0;
    end else if (hready_o) begin
      dph  <= htrans_i == dwp_pkg::HTRANS_NONSEQ;
      ph_a <= haddr_i;
      ph_s <= hsize_i;
      ph_w <= hwrite_i;
    end
  end
endmodule

// ==== testbench/dma_width_packing_and_error_tb_top.sv ====
// Self-checking bench: width table, bus errors, refused accesses.
// Assumes the memory model starts with bytes b0, b1, b2 ... from 0.
`timescale 1ns/1ps
module dma_width_packing_and_error_tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq_o, hwrite_o;
  logic [7:0] wb_adr_i, chan_irq_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, haddr_o, hwdata_o, hrdata_i, rdat;
  logic [1:0] htrans_o;
  logic [2:0] hsize_o;
  logic hready_i, hresp_i, slow, rerr;
  int num_errors, checked, cycles;
  dwp_dma_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o),
    .chan_irq_o(chan_irq_o), .haddr_o(haddr_o), .htrans_o(htrans_o), .hwrite_o(hwrite_o),
    .hsize_o(hsize_o), .hwdata_o(hwdata_o), .hrdata_i(hrdata_i), .hready_i(hready_i),
    .hresp_i(hresp_i));
  dwp_ahb_mem mdl (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .haddr_i(haddr_o),
    .htrans_i(htrans_o), .hwrite_i(hwrite_o), .hsize_i(hsize_o), .hwdata_i(hwdata_o),
    .hrdata_o(hrdata_i), .hready_o(hready_i), .hresp_o(hresp_i));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Hold the request until ack or err, then idle a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    rdat = wb_dat_o;
    rerr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Two items per size pair; the third slot must stay untouched
  task automatic width_case(input int s, input int d);
    logic [31:0] ex;
    int ss, ds;
    ss = 1 << s;
    ds = 1 << d;
    slow <= s[0];
    for (int i = 128; i < 144; i++) mdl.mem[i] = 8'h00;
    wb(1, 8'h80, 0, 4'hf);
    wb(1, 8'h84, 2, 4'hf);
    wb(1, 8'h88, 0, 4'hf);
    wb(1, 8'h8c, 32'h80, 4'hf);
    wb(1, 8'h80, 32'hc1 | (s << 8) | (d << 10), 4'hf);
    do wb(0, 8'h00, 0, 4'hf); while (rdat[1] !== 1'b1);
    check(32'(rdat[3:0]), 32'h7);
    for (int n = 0; n < 3*ds; n++) begin
      ex = (n < 2*ds && n%ds < ss) ? 32'hb0 + n/ds*ss + n%ds : 0;
      check(32'(mdl.mem[128+n]), ex);
    end
    wb(1, 8'h04, 32'hf, 4'hf);
    wb(0, 8'h00, 0, 4'hf);
    check(rdat, 0);
  endtask
  // Read from reserved space, then refused and unmapped accesses
  task automatic error_case();
    slow <= 1'b0;
    wb(1, 8'h80, 0, 4'hf);
    wb(1, 8'h84, 3, 4'hf);
    wb(1, 8'h8c, 32'h8000_0000, 4'hf);
    wb(1, 8'h08, 32'h8, 4'hf);
    wb(1, 8'h80, 32'hd9, 4'hf);
    repeat (10) @(posedge clk_i);
    check(32'(irq_o), 1);
    check(32'(chan_irq_o), 32'h1);
    wb(0, 8'h80, 0, 4'hf);
    check(32'(rdat[0]), 0);
    wb(0, 8'h00, 0, 4'hf);
    check(32'(rdat[3:0]), 32'h9);
    repeat (20) begin
      @(posedge clk_i);
      check(32'(htrans_o), 0);
    end
    wb(1, 8'h04, 32'hf, 4'hf);
    check(32'(irq_o), 0);
    wb(0, 8'h00, 0, 4'h3);
    check(32'(rerr), 1);
    wb(0, 8'h40, 0, 4'hf);
    check(rdat, 0);
  endtask
  // ------------------------------
  // Clock, sequence and watchdog
  // ------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 47'h0};
    slow = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 3; s++)
      for (int d = 0; d < 3; d++) width_case(s, d);
    error_case();
    give_verdict();
  end
  // Whole run needs a few hundred cycles; a hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      give_verdict();
    end
  end
endmodule
